// ---- logic/sfpf_consts.vh ----
// constants for the serial flash protect and address front end
`ifndef SFPF_CONSTS_VH
`define SFPF_CONSTS_VH

// apb byte offsets
`define SFPF_OFF_PROTECT 12'h000
`define SFPF_OFF_SEGMENT 12'h004
`define SFPF_OFF_STATUS 12'h008
`define SFPF_OFF_SECURITY 12'h00C
`define SFPF_OFF_SECT_LOCK 12'h010
`define SFPF_OFF_BLK_LOCK 12'h040
`define SFPF_OFF_BLK_LOCK_END 12'h07C

// protect register fields
`define SFPF_PROT_LVL_LSB 0
`define SFPF_PROT_TB_BIT 4
`define SFPF_PROT_RST 5'h00
`define SFPF_PROT_ALL_LEVEL 4'hA
`define SFPF_BLOCKS 10'h200
`define SFPF_TOP_BLOCK 9'h1FF

// status byte fields (link status read and apb status)
`define SFPF_ST_BUSY_BIT 0
`define SFPF_ST_WEL_BIT 1
`define SFPF_ST_OTP_BIT 6
`define SFPF_ST_WIDE_BIT 7
// security byte fields
`define SFPF_SEC_FACTORY_BIT 0
`define SFPF_SEC_CUST_BIT 1
// configuration byte field of the wide address flag
`define SFPF_CFG_WIDE_BIT 5
`define SFPF_SEG_EXT_RST 1'b0
`define SFPF_OTP_SERIAL_END 9'h00F

// opcodes
`define SFPF_OP_WREN 8'h06
`define SFPF_OP_WRDI 8'h04
`define SFPF_OP_RDSR 8'h05
`define SFPF_OP_RDCR 8'h15
`define SFPF_OP_READ 8'h03
`define SFPF_OP_READ4B 8'h13
`define SFPF_OP_PP 8'h02
`define SFPF_OP_PP4B 8'h12
`define SFPF_OP_SE 8'h20
`define SFPF_OP_SE4B 8'h21
`define SFPF_OP_BE32 8'h52
`define SFPF_OP_BE32_4B 8'h5C
`define SFPF_OP_BE64 8'hD8
`define SFPF_OP_BE64_4B 8'hDC
`define SFPF_OP_CE_A 8'h60
`define SFPF_OP_CE_B 8'hC7
`define SFPF_OP_ENTER_OTP 8'hB1
`define SFPF_OP_EXIT_OTP 8'hC1
`define SFPF_OP_WRITE_SEC 8'h2F
`define SFPF_OP_READ_SEC 8'h2B
`define SFPF_OP_ENTER_WIDE 8'hB7
`define SFPF_OP_EXIT_WIDE 8'hE9
`define SFPF_OP_WR_SEG 8'hC5
`define SFPF_OP_RD_SEG 8'hC8

// command classes
`define SFPF_CL_BAD 3'h0
`define SFPF_CL_NONE 3'h1
`define SFPF_CL_PGM 3'h2
`define SFPF_CL_ERASE 3'h3
`define SFPF_CL_READ 3'h4
`define SFPF_CL_REG_RD 3'h5
`define SFPF_CL_REG_WR 3'h6
`define SFPF_CL_CHIP 3'h7

// kinds of array operation on CMD_KIND
`define SFPF_K_PGM 3'h1
`define SFPF_K_SE 3'h2
`define SFPF_K_BE32 3'h3
`define SFPF_K_BE64 3'h4
`define SFPF_K_CE 3'h5

`endif

// ---- logic/sfpf_front_end.v ----
// serial flash front end: command framing, protection, otp control, address modes
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "sfpf_consts.vh"

module sfpf_front_end (
    input wire CLK,
    input wire RST_N,
    input wire CE,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output reg PSLVERR,
    input wire SCLK,
    input wire CS_N,
    input wire SI,
    output reg SO,
    output reg SO_OE,
    input wire ARRAY_BUSY,
    input wire FACTORY_LOCK,
    input wire CUST_LOCK_NV,
    output reg CUST_LOCK_SET,
    output reg OTP_MODE,
    output reg WIDE_ADDR,
    output reg [24:0] ARR_ADDR,
    output reg ARR_RD,
    input wire [7:0] ARR_RDATA,
    output reg DIN_VALID,
    output reg [7:0] DIN_BYTE,
    output reg CMD_GO,
    output reg [2:0] CMD_KIND
);

    localparam ST_IDLE = 3'h0;
    localparam ST_OPC = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_DATAIN = 3'h3;
    localparam ST_DATAOUT = 3'h4;
    localparam ST_DONE = 3'h5;
    localparam ST_STANDBY = 3'h6;

    function [2:0] cmd_class(input [7:0] op);
        begin
            case (op)
                `SFPF_OP_WREN, `SFPF_OP_WRDI, `SFPF_OP_ENTER_OTP, `SFPF_OP_EXIT_OTP,
                `SFPF_OP_WRITE_SEC, `SFPF_OP_ENTER_WIDE, `SFPF_OP_EXIT_WIDE:
                    cmd_class = `SFPF_CL_NONE;
                `SFPF_OP_PP, `SFPF_OP_PP4B: cmd_class = `SFPF_CL_PGM;
                `SFPF_OP_SE, `SFPF_OP_SE4B, `SFPF_OP_BE32, `SFPF_OP_BE32_4B,
                `SFPF_OP_BE64, `SFPF_OP_BE64_4B: cmd_class = `SFPF_CL_ERASE;
                `SFPF_OP_CE_A, `SFPF_OP_CE_B: cmd_class = `SFPF_CL_CHIP;
                `SFPF_OP_READ, `SFPF_OP_READ4B: cmd_class = `SFPF_CL_READ;
                `SFPF_OP_RDSR, `SFPF_OP_RDCR, `SFPF_OP_READ_SEC, `SFPF_OP_RD_SEG:
                    cmd_class = `SFPF_CL_REG_RD;
                `SFPF_OP_WR_SEG: cmd_class = `SFPF_CL_REG_WR;
                default: cmd_class = `SFPF_CL_BAD;
            endcase
        end
    endfunction

    function is_4b(input [7:0] op);
        begin
            is_4b = (op == `SFPF_OP_READ4B) || (op == `SFPF_OP_PP4B) || (op == `SFPF_OP_SE4B) ||
                (op == `SFPF_OP_BE32_4B) || (op == `SFPF_OP_BE64_4B);
        end
    endfunction

    function [2:0] cmd_kind(input [7:0] op);
        begin
            case (op)
                `SFPF_OP_SE, `SFPF_OP_SE4B: cmd_kind = `SFPF_K_SE;
                `SFPF_OP_BE32, `SFPF_OP_BE32_4B: cmd_kind = `SFPF_K_BE32;
                `SFPF_OP_BE64, `SFPF_OP_BE64_4B: cmd_kind = `SFPF_K_BE64;
                `SFPF_OP_CE_A, `SFPF_OP_CE_B: cmd_kind = `SFPF_K_CE;
                default: cmd_kind = `SFPF_K_PGM;
            endcase
        end
    endfunction

    // true when the unit touched by an operation of this kind is protected; chip erase checks the level and sector locks only
    function prot_hit(input [24:0] a, input [3:0] lvl, input tb, input [31:0] lkw,
        input [31:0] sec, input [2:0] kind);
        reg [8:0] blk;
        reg [9:0] n;
        reg [15:0] smask;
        reg [15:0] sl;
        begin
            blk = a[24:16];
            n = 10'h001 << (lvl - 4'h1);
            sl = (blk == 9'h000) ? sec[15:0] : sec[31:16];
            smask = (kind == `SFPF_K_BE64) ? 16'hFFFF :
                (kind == `SFPF_K_BE32) ? (a[15] ? 16'hFF00 : 16'h00FF) :
                (16'h0001 << a[15:12]);
            if (lvl >= `SFPF_PROT_ALL_LEVEL)
                prot_hit = 1'b1;
            else if (lvl == 4'h0)
                prot_hit = 1'b0;
            else if (tb)
                prot_hit = ({1'b0, blk} < n);
            else
                prot_hit = ({1'b0, blk} >= (`SFPF_BLOCKS - n));
            if (kind == `SFPF_K_CE)
                prot_hit = (lvl != 4'h0) || (|sec);
            else if (blk == 9'h000 || blk == `SFPF_TOP_BLOCK)
                prot_hit = prot_hit | (|(sl & smask));
            else
                prot_hit = prot_hit | lkw[blk[4:0]];
        end
    endfunction

    // otp accesses land on the 512-byte region; 3-byte addresses take the segment bit
    function [24:0] eff_addr(input [31:0] a, input four, input seg, input otp);
        begin
            if (otp)
                eff_addr = {16'h0000, a[8:0]};
            else if (four)
                eff_addr = a[24:0];
            else
                eff_addr = {seg, a[23:0]};
        end
    endfunction

    reg cs_s1, cs_s2, cs_d;
    reg sck_s1, sck_s2, sck_d;
    reg si_s1, si_s2;
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [2:0] addr_left;
    reg [7:0] shift_in;
    reg [7:0] opcode;
    reg [31:0] addr;
    reg [7:0] out_shift;
    reg [7:0] out_reload;
    reg [8:0] din_cnt;
    reg [7:0] seg_byte;
    reg rd_load;
    reg wel;
    reg seg_bit;
    reg fac_lock;
    reg cust_lock;
    reg [4:0] prot_cfg;
    reg [31:0] sect_lock;
    reg [31:0] blk_lock [0:15];
    reg apb_rdy;
    reg [31:0] apb_rd;
    reg apb_hit;
    integer i;

    wire cs_fall = cs_d & ~cs_s2;
    wire cs_rise = ~cs_d & cs_s2;
    wire sck_rise = ~sck_d & sck_s2 & ~cs_s2;
    wire sck_fall = sck_d & ~sck_s2 & ~cs_s2;
    wire [7:0] nb = {shift_in[6:0], si_s2};
    wire four = WIDE_ADDR | is_4b(opcode);
    wire [2:0] ocl = cmd_class(opcode);
    wire [7:0] st_byte = {WIDE_ADDR, OTP_MODE, prot_cfg[3:0], wel, ARRAY_BUSY};
    wire [7:0] sec_byte = {5'h00, OTP_MODE, cust_lock, fac_lock};
    wire [7:0] reg_rd_byte = (nb == `SFPF_OP_RDSR) ? st_byte :
        (nb == `SFPF_OP_RDCR) ? {2'b00, WIDE_ADDR, 5'h00} :
        (nb == `SFPF_OP_READ_SEC) ? sec_byte : {7'h00, seg_bit};
    wire [31:0] lock_word = blk_lock[ARR_ADDR[24:21]];
    wire blocked = prot_hit(ARR_ADDR, prot_cfg[3:0], prot_cfg[`SFPF_PROT_TB_BIT], lock_word,
        sect_lock, CMD_KIND);
    // factory lock guards the serial number words, customer lock the whole region
    wire otp_blocked = cust_lock | (fac_lock & (ARR_ADDR[8:0] <= `SFPF_OTP_SERIAL_END));
    wire apb_wr = PSEL & PENABLE & PWRITE & apb_rdy;

    // one access cycle, no waits, while the clock enable runs
    assign PREADY = apb_rdy & CE;

    always @* begin
        apb_rd = 32'h00000000;
        apb_hit = 1'b1;
        if (PADDR == `SFPF_OFF_PROTECT)
            apb_rd = {27'h0000000, prot_cfg};
        else if (PADDR == `SFPF_OFF_SEGMENT)
            apb_rd = {31'h00000000, seg_bit};
        else if (PADDR == `SFPF_OFF_STATUS)
            apb_rd = {24'h000000, st_byte};
        else if (PADDR == `SFPF_OFF_SECURITY)
            apb_rd = {24'h000000, sec_byte};
        else if (PADDR == `SFPF_OFF_SECT_LOCK)
            apb_rd = sect_lock;
        else if (PADDR >= `SFPF_OFF_BLK_LOCK && PADDR <= `SFPF_OFF_BLK_LOCK_END &&
            PADDR[1:0] == 2'b00)
            apb_rd = blk_lock[PADDR[5:2]];
        else
            apb_hit = 1'b0;
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_d <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
            state <= ST_IDLE;
            bit_cnt <= 3'h0;
            addr_left <= 3'h0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            addr <= 32'h00000000;
            out_shift <= 8'h00;
            out_reload <= 8'h00;
            din_cnt <= 9'h000;
            seg_byte <= 8'h00;
            rd_load <= 1'b0;
            wel <= 1'b0;
            seg_bit <= `SFPF_SEG_EXT_RST;
            fac_lock <= 1'b0;
            cust_lock <= 1'b0;
            prot_cfg <= `SFPF_PROT_RST;
            sect_lock <= 32'h00000000;
            for (i = 0; i < 16; i = i + 1)
                blk_lock[i] <= 32'h00000000;
            apb_rdy <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
            SO <= 1'b0;
            SO_OE <= 1'b0;
            CUST_LOCK_SET <= 1'b0;
            OTP_MODE <= 1'b0;
            WIDE_ADDR <= 1'b0;
            ARR_ADDR <= 25'h0000000;
            ARR_RD <= 1'b0;
            DIN_VALID <= 1'b0;
            DIN_BYTE <= 8'h00;
            CMD_GO <= 1'b0;
            CMD_KIND <= 3'h0;
        end else if (CE) begin
            cs_s1 <= CS_N;
            cs_s2 <= cs_s1;
            cs_d <= cs_s2;
            sck_s1 <= SCLK;
            sck_s2 <= sck_s1;
            sck_d <= sck_s2;
            si_s1 <= SI;
            si_s2 <= si_s1;
            ARR_RD <= 1'b0;
            DIN_VALID <= 1'b0;
            CMD_GO <= 1'b0;
            CUST_LOCK_SET <= 1'b0;
            // lock indicators only ever accumulate
            fac_lock <= fac_lock | FACTORY_LOCK;
            cust_lock <= cust_lock | CUST_LOCK_NV;
            rd_load <= ARR_RD;
            if (rd_load)
                out_shift <= ARR_RDATA;

            apb_rdy <= PSEL & ~PENABLE;
            if (PSEL & ~PENABLE) begin
                PRDATA <= PWRITE ? 32'h00000000 : apb_rd;
                PSLVERR <= ~apb_hit;
            end
            if (apb_wr && apb_hit) begin
                if (PADDR == `SFPF_OFF_PROTECT)
                    prot_cfg <= PWDATA[4:0];
                else if (PADDR == `SFPF_OFF_SEGMENT)
                    seg_bit <= PWDATA[0];
                else if (PADDR == `SFPF_OFF_SECT_LOCK)
                    sect_lock <= PWDATA;
                else if (PADDR >= `SFPF_OFF_BLK_LOCK)
                    blk_lock[PADDR[5:2]] <= PWDATA;
            end

            if (cs_rise) begin
                state <= ST_IDLE;
                SO_OE <= 1'b0;
                // write type work only runs on a whole byte count
                if (bit_cnt == 3'h0 && (state == ST_DONE ||
                    (state == ST_DATAIN && din_cnt != 9'h000))) begin
                    case (ocl)
                        `SFPF_CL_NONE: begin
                            if (opcode == `SFPF_OP_WREN)
                                wel <= 1'b1;
                            else if (opcode == `SFPF_OP_WRDI)
                                wel <= 1'b0;
                            else if (opcode == `SFPF_OP_ENTER_OTP)
                                OTP_MODE <= 1'b1;
                            else if (opcode == `SFPF_OP_EXIT_OTP)
                                OTP_MODE <= 1'b0;
                            else if (opcode == `SFPF_OP_ENTER_WIDE)
                                WIDE_ADDR <= 1'b1;
                            else if (opcode == `SFPF_OP_EXIT_WIDE)
                                WIDE_ADDR <= 1'b0;
                            else if (opcode == `SFPF_OP_WRITE_SEC && wel) begin
                                cust_lock <= 1'b1;
                                CUST_LOCK_SET <= 1'b1;
                                wel <= 1'b0;
                            end
                        end
                        `SFPF_CL_REG_WR:
                            seg_bit <= seg_byte[0];
                        `SFPF_CL_PGM: begin
                            wel <= 1'b0;
                            if (wel && !ARRAY_BUSY && !(OTP_MODE ? otp_blocked : blocked))
                                CMD_GO <= 1'b1;
                        end
                        `SFPF_CL_ERASE, `SFPF_CL_CHIP: begin
                            wel <= 1'b0;
                            if (wel && !ARRAY_BUSY && !OTP_MODE && !blocked)
                                CMD_GO <= 1'b1;
                        end
                        default: ;
                    endcase
                end
            end else if (cs_fall) begin
                state <= ST_OPC;
                bit_cnt <= 3'h0;
                SO_OE <= 1'b0;
            end else if (sck_rise && (state == ST_OPC || state == ST_ADDR ||
                state == ST_DATAIN || state == ST_DONE)) begin
                shift_in <= nb;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    case (state)
                        ST_OPC: begin
                            opcode <= nb;
                            addr <= 32'h00000000;
                            din_cnt <= 9'h000;
                            CMD_KIND <= cmd_kind(nb);
                            case (cmd_class(nb))
                                `SFPF_CL_BAD:
                                    state <= ST_STANDBY;
                                `SFPF_CL_PGM, `SFPF_CL_ERASE, `SFPF_CL_READ: begin
                                    state <= ST_ADDR;
                                    addr_left <= (WIDE_ADDR | is_4b(nb)) ? 3'h4 : 3'h3;
                                end
                                `SFPF_CL_REG_RD: begin
                                    state <= ST_DATAOUT;
                                    out_reload <= reg_rd_byte;
                                    out_shift <= reg_rd_byte;
                                end
                                `SFPF_CL_REG_WR:
                                    state <= ST_DATAIN;
                                default: begin
                                    state <= ST_DONE;
                                    ARR_ADDR <= 25'h0000000;
                                end
                            endcase
                        end
                        ST_ADDR: begin
                            addr <= {addr[23:0], nb};
                            addr_left <= addr_left - 3'h1;
                            if (addr_left == 3'h1) begin
                                ARR_ADDR <= eff_addr({addr[23:0], nb}, four, seg_bit, OTP_MODE);
                                if (ocl == `SFPF_CL_PGM)
                                    state <= ST_DATAIN;
                                else if (ocl == `SFPF_CL_READ && !ARRAY_BUSY) begin
                                    state <= ST_DATAOUT;
                                    ARR_RD <= 1'b1;
                                end else
                                    state <= ST_DONE;
                            end
                        end
                        ST_DATAIN: begin
                            din_cnt <= din_cnt + 9'h001;
                            if (ocl == `SFPF_CL_REG_WR)
                                seg_byte <= nb;
                            else begin
                                DIN_VALID <= 1'b1;
                                DIN_BYTE <= nb;
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (sck_fall && state == ST_DATAOUT) begin
                SO <= out_shift[7];
                SO_OE <= 1'b1;
                out_shift <= {out_shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    if (ocl == `SFPF_CL_READ) begin
                        // the pointer runs on over the segment edge, segment bit untouched
                        ARR_ADDR <= OTP_MODE ? {16'h0000, ARR_ADDR[8:0] + 9'h001} :
                            ARR_ADDR + 25'h0000001;
                        ARR_RD <= 1'b1;
                    end else
                        out_shift <= out_reload;
                end
            end
        end
    end

endmodule

// ---- tb/sfpf_monitor.sv ----
// port assertions for the flash front end
`timescale 1ns/10ps
`include "sfpf_consts.vh"
module sfpf_monitor (
    input wire CLK,
    input wire RST_N,
    input wire CS_N,
    input wire SO_OE,
    input wire ARRAY_BUSY,
    input wire CMD_GO,
    input wire [2:0] CMD_KIND,
    input wire OTP_MODE,
    input wire WIDE_ADDR,
    input wire CUST_LOCK_SET,
    input wire DIN_VALID,
    input wire ARR_RD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // select passes a two-flop synchroniser, so allow a few cycles before judging
    sequence s_quiet; CS_N [*5]; endsequence
    sequence s_lock_once; CS_N ##1 !CUST_LOCK_SET; endsequence
    a_idle_out_off: assert property (s_quiet |-> !SO_OE)
        else $error("output driven while deselected");
    a_go_after_rise: assert property (CMD_GO |-> CS_N && $past(CS_N, 2))
        else $error("operation started inside a frame");
    a_otp_no_erase: assert property (OTP_MODE && CMD_GO |-> CMD_KIND == `SFPF_K_PGM)
        else $error("array operation in otp mode");
    a_busy_no_go: assert property (ARRAY_BUSY && $past(ARRAY_BUSY) |-> !CMD_GO)
        else $error("operation started while busy");
    a_lock_pulse: assert property (CUST_LOCK_SET |-> s_lock_once)
        else $error("lock store pulse malformed");
    a_wide_on_rise: assert property ($changed(WIDE_ADDR) |-> CS_N)
        else $error("address mode changed inside a frame");
    a_otp_on_rise: assert property ($changed(OTP_MODE) |-> CS_N)
        else $error("otp mode changed inside a frame");
    a_byte_gap: assert property (DIN_VALID |=> !DIN_VALID [*8])
        else $error("data bytes too close together");
    a_read_pulse: assert property (ARR_RD |=> !ARR_RD)
        else $error("array read strobe longer than one cycle");
endmodule
bind sfpf_front_end sfpf_monitor mon (.CLK, .RST_N, .CS_N, .SO_OE, .ARRAY_BUSY, .CMD_GO,
    .CMD_KIND, .OTP_MODE, .WIDE_ADDR, .CUST_LOCK_SET, .DIN_VALID, .ARR_RD);

// ---- tb/sfpf_host_model.sv ----
// host controller model for the serial link
`timescale 1ns/10ps
module sfpf_host_model (
    input wire logic clk,
    input wire logic so,
    output logic sclk = 1'h0,
    output logic cs_n = 1'h1,
    output logic si = 1'h0
);
    logic idle = 1'h0;
    logic [7:0] rd;
    // nb bytes of tx go out msb first; n bits are clocked in all, the rest read back
    task automatic frame(input logic [47:0] tx, input int nb, n);
        tx = tx << (48 - 8 * nb);
        @(posedge clk);
        sclk <= idle;
        repeat (16) @(posedge clk);
        cs_n <= 1'h0;
        repeat (n) begin
            sclk <= 1'h0;
            si <= tx[47];
            tx = tx << 1;
            repeat (16) @(posedge clk);
            rd = {rd[6:0], so};
            sclk <= 1'h1;
            repeat (16) @(posedge clk);
        end
        sclk <= idle;
        repeat (16) @(posedge clk);
        cs_n <= 1'h1;
        si <= ~si;
        repeat (16) @(posedge clk);
    endtask
endmodule

// ---- tb/test_serial_flash_protect_addr_front_end.sv ----
// self-checking bench for the flash front end
`timescale 1ns/10ps
`include "sfpf_consts.vh"
module test_serial_flash_protect_addr_front_end;
    logic CLK = 1'h0, RST_N = 1'h0, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic ARRAY_BUSY = 1'h0, PREADY, PSLVERR, SCLK, CS_N, SI, SO, SO_OE, CUST_LOCK_SET;
    logic FACTORY_LOCK = 1'h0, OTP_MODE, WIDE_ADDR, CMD_GO, oe_seen, err;
    logic [2:0] CMD_KIND;
    logic [7:0] DIN_BYTE;
    logic [11:0] PADDR = 12'h000;
    logic [24:0] ARR_ADDR, go_addr;
    logic [31:0] PWDATA = 32'h0, PRDATA, r;
    int failures = 0, n_tests = 0, n_go = 0, n_lock = 0;
    // a released output shows the inverse, so an undriven bit cannot pass as data
    wire so_pin = SO_OE ? SO : ~SO;
    always #2.5 CLK = ~CLK;
    sfpf_front_end dut (.CLK, .RST_N, .CE(1'h1), .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .SCLK, .CS_N, .SI, .SO, .SO_OE, .ARRAY_BUSY,
        .FACTORY_LOCK, .CUST_LOCK_NV(1'h0), .CUST_LOCK_SET, .OTP_MODE, .WIDE_ADDR,
        .ARR_ADDR, .ARR_RD(), .ARR_RDATA(8'h5A), .DIN_VALID(), .DIN_BYTE, .CMD_GO, .CMD_KIND);
    sfpf_host_model host (.clk(CLK), .so(so_pin), .sclk(SCLK), .cs_n(CS_N), .si(SI));
    always @(posedge CLK) begin
        oe_seen = oe_seen | SO_OE;
        n_lock += (CUST_LOCK_SET === 1'h1);
        n_go += (CMD_GO === 1'h1);
        if (CMD_GO === 1'h1) go_addr = ARR_ADDR;
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic complete_run(input logic hung);
        failures += hung;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
        @(posedge CLK) PENABLE <= 1'h1;
        do @(posedge CLK); while (PREADY !== 1'h1 && ++i < 50);
        if (i >= 50) complete_run(1'h1);
        {r, err} = {PRDATA, PSLVERR};
        {PSEL, PENABLE} <= 2'h0;
    endtask
    // every attempt is armed first, so a refusal can only come from the case under test
    task automatic go(input logic [4:0] p, input logic [47:0] tx, input int nb, n,
        input logic ok, input logic [24:0] ea);
        int g = n_go;
        apb(1'h1, `SFPF_OFF_PROTECT, {27'h0, p});
        host.frame(48'h06, 1, 8);
        host.frame(tx, nb, n);
        chk("go count", n_go - g, ok);
        if (ok) chk("go address", go_addr, ea);
    endtask
    task automatic t_prot;
        apb(1'h1, 12'hFFC, 32'h1);
        chk("unmapped error", err, 32'h1);
        go(5'h11, {8'h20, 24'h000000}, 4, 32, 1'h0, 25'h0);
        go(5'h11, {8'h20, 24'h010000}, 4, 32, 1'h1, 25'h0010000);
        go(5'h19, {8'h21, 32'h00FF0000}, 5, 40, 1'h0, 25'h0);
        go(5'h19, {8'h21, 32'h01000000}, 5, 40, 1'h1, 25'h1000000);
        go(5'h1A, {8'h21, 32'h01FF0000}, 5, 40, 1'h0, 25'h0);
        go(5'h01, {8'h21, 32'h01FF0000}, 5, 40, 1'h0, 25'h0);
        go(5'h01, {8'h21, 32'h01FE0000}, 5, 40, 1'h1, 25'h1FE0000);
        apb(1'h1, `SFPF_OFF_SECT_LOCK, 32'h4);
        go(5'h00, {8'h20, 24'h002000}, 4, 32, 1'h0, 25'h0);
        go(5'h00, {8'h20, 24'h003000}, 4, 32, 1'h1, 25'h0003000);
        go(5'h00, 48'h60, 1, 8, 1'h0, 25'h0);
        apb(1'h1, `SFPF_OFF_BLK_LOCK, 32'h4);
        go(5'h00, {8'h20, 24'h020000}, 4, 32, 1'h0, 25'h0);
        apb(1'h1, `SFPF_OFF_SECT_LOCK, 32'h0);
        apb(1'h1, `SFPF_OFF_BLK_LOCK, 32'h0);
        go(5'h00, 48'h60, 1, 8, 1'h1, 25'h0);
    endtask
    task automatic t_wide;
        apb(1'h0, `SFPF_OFF_SEGMENT, 32'h0);
        chk("segment reset", r, 32'h0);
        apb(1'h1, `SFPF_OFF_SEGMENT, 32'hFF);
        apb(1'h0, `SFPF_OFF_SEGMENT, 32'h0);
        chk("segment upper bits", r, 32'h1);
        host.frame(48'hB7, 1, 8);
        chk("wide on", WIDE_ADDR, 32'h1);
        go(5'h00, {8'h20, 32'h00010000}, 5, 40, 1'h1, 25'h0010000);
        host.frame(48'hE9, 1, 8);
        go(5'h00, {8'h20, 24'h010000}, 4, 32, 1'h1, 25'h1010000);
        apb(1'h1, `SFPF_OFF_SEGMENT, 32'h0);
        host.frame({8'h03, 24'hFFFFFF}, 4, 48);
        chk("read data", host.rd, 32'h5A);
        chk("read crossing", ARR_ADDR, 32'h1000001);
        apb(1'h0, `SFPF_OFF_SEGMENT, 32'h0);
        chk("segment kept", r, 32'h0);
    endtask
    task automatic t_link;
        go(5'h00, {8'h20, 24'h010000}, 4, 35, 1'h0, 25'h0);
        oe_seen = 1'h0;
        host.frame(48'hFF, 1, 24);
        chk("standby output", oe_seen, 32'h0);
        host.idle = 1'h1;
        host.frame(48'h06, 1, 8);
        host.frame(48'h05, 1, 16);
        chk("status in mode 3", host.rd, 32'h02);
        host.frame(48'h05, 1, 11);
        chk("cut read", SO_OE, 32'h0);
        host.idle = 1'h0;
        ARRAY_BUSY <= 1'h1;
        go(5'h00, {8'h20, 24'h010000}, 4, 32, 1'h0, 25'h0);
        ARRAY_BUSY <= 1'h0;
    endtask
    task automatic t_otp;
        host.frame(48'hB1, 1, 8);
        chk("otp on", OTP_MODE, 32'h1);
        go(5'h00, {8'h20, 24'h010000}, 4, 32, 1'h0, 25'h0);
        go(5'h00, {8'h02, 24'h000010, 8'hA5}, 5, 40, 1'h1, 25'h10);
        chk("otp data", DIN_BYTE, 32'hA5);
        host.frame(48'h06, 1, 8);
        host.frame(48'h2F, 1, 8);
        chk("customer lock", n_lock, 32'h1);
        go(5'h00, {8'h02, 24'h000020, 8'h3C}, 5, 40, 1'h0, 25'h0);
        host.frame(48'hC1, 1, 8);
        chk("otp off", OTP_MODE, 32'h0);
        FACTORY_LOCK <= 1'h1;
        apb(1'h0, `SFPF_OFF_SECURITY, 32'h0);
        chk("factory lock", r, 32'h3);
        FACTORY_LOCK <= 1'h0;
        apb(1'h0, `SFPF_OFF_SECURITY, 32'h0);
        chk("locks kept", r, 32'h3);
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'h1;
        repeat (5) @(posedge CLK);
        t_prot();
        t_wide();
        t_link();
        t_otp();
        complete_run(1'h0);
    end
    initial begin
        repeat (100000) @(posedge CLK);
        complete_run(1'h1);
    end
endmodule
